/* File: rtl/spe_pkg.sv */
package spe_pkg;

  // one-byte opcodes, most significant bit first on the wire
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_WRITE     = 8'h02;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_STAT_RD   = 8'h05;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;

  localparam int          ADDR_W     = 16;
  localparam int          PAGE_W     = 7;
  localparam int          PAGE_BYTES = 128;
  localparam logic [15:0] GUARD_QTR  = 16'hC000;
  localparam logic [15:0] GUARD_HALF = 16'h8000;
  localparam logic [2:0]  STAT_RSVD  = 3'h0;
  localparam logic [1:0]  BG_NONE    = 2'h0;
  localparam logic [1:0]  BG_QTR     = 2'h1;
  localparam logic [1:0]  BG_HALF    = 2'h2;

  // byte phases inside a frame: opcode, address high, address low, data
  localparam logic [1:0]  PH_OP   = 2'h0;
  localparam logic [1:0]  PH_AH   = 2'h1;
  localparam logic [1:0]  PH_AL   = 2'h2;
  localparam logic [1:0]  PH_DATA = 2'h3;

  // status lock, guard bits and latch come up cleared
  localparam logic        LOCK_RST = 1'h0;
  localparam logic [1:0]  BG_RST   = 2'h0;
  localparam logic        WEL_RST  = 1'h0;
  localparam int          NV_PROG_CYCLES_DEF = 1000;

  typedef enum logic [2:0] {SPE_K_NONE, SPE_K_SET, SPE_K_CLR, SPE_K_STAT, SPE_K_MEM} spe_kind_t;
  typedef enum logic [2:0] {SPE_OP_NONE, SPE_OP_READ, SPE_OP_WRITE, SPE_OP_STAT_WR,
                            SPE_OP_STAT_RD, SPE_OP_LATCH, SPE_OP_IGNORE} spe_op_t;

  typedef struct packed {
    logic       lock;
    logic [2:0] rsvd;
    logic [1:0] bg;
    logic       write_enable_latch;
    logic       busy;
  } spe_stat_t;

  // true when the address sits inside the block-guarded region
  function automatic logic spe_guarded(input logic [15:0] a, input logic [1:0] bg);
    case (bg)
      BG_NONE: spe_guarded = 1'b0;
      BG_QTR:  spe_guarded = (a >= GUARD_QTR);
      BG_HALF: spe_guarded = (a >= GUARD_HALF);
      default: spe_guarded = 1'b1;
    endcase
  endfunction : spe_guarded

endpackage : spe_pkg

/* File: rtl/spe_eeprom.sv */
`timescale 1ns/1ps
// What this block does
// - status write takes only lock and guard bits from its data; bits 6..4 read zero
// - status write runs only if select rises after exactly 16 clocks
// - busy reads 1 during the status write cycle; latch clears at its end
// - lock and guard bits keep old values until the status cycle completes
// - lock set with protect pin low blocks status writes
// - read takes a 16-bit address and shifts out that byte
// - read address increments per byte and wraps to zero
// - a read ends at once when select goes high
// - read opcode is not accepted while a write cycle runs
// - memory write starts only if select rises after 24 plus 8m clocks
// - memory write completion clears busy and latch
// - page of 128 bytes; in a memory write only low 7 address bits increment and wrap
// - memory write refused without latch, while busy, or in guarded area
// - protect pin high releases hardware lock; guard bits still apply
// - hold floats the output and ignores input and clock
// - pause change with clock low stops shifting at once; the output floats at the next falling clock
// - pause change with clock high takes effect at next falling clock
// - select high during hold abandons the operation
// - opcodes 03h read, 02h write, 01h status write, own codes others
// - only latch-set sets the latch; clear, reset and write end clear it
// - sample on rising clock edges, change output on falling edges
// - unknown opcode ignores the rest of the frame
module spe_eeprom
  import spe_pkg::*;
#(
  parameter int PROG_CYCLES = NV_PROG_CYCLES_DEF
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  input  wire logic hold_n,
  output logic      so,
  output logic      so_oe
);

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  initial begin
    if (PROG_CYCLES < 2) $error("PROG_CYCLES must be at least 2");
  end

  typedef enum logic [1:0] {SPE_PG_IDLE, SPE_PG_COPY, SPE_PG_WAIT} spe_pg_t;

  // link side (sck domain)
  wire logic      lrst_n = nrst & ~cs_n;  // select high ends the frame, also under hold
  logic [2:0]     bit_q;
  logic [1:0]     ph_q;
  spe_op_t        op_q;
  logic [7:0]     sh_q;
  logic [7:0]     tx_q;
  logic [15:0]    addr_q;
  logic [7:0]     stat_new_q;
  spe_kind_t      kind_q;
  logic [7:0]     pg_buf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pg_vld_q;
  spe_stat_t      st_l1_q, st_l2_q;

  // system side (clk domain)
  logic [7:0]     mem_q [2**ADDR_W];
  logic           cs1_q, cs2_q, cs3_q, wp1_q, wp2_q, h1_q, h2_q;
  logic [2:0]     k1_q, k2_q;
  spe_pg_t        pg_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [PAGE_W-1:0] idx_q;
  logic [ADDR_W-PAGE_W-1:0] base_q;
  logic           is_stat_q, busy_q, wel_q, lock_q, done_q;
  logic [1:0]     bg_q;
  spe_stat_t      stat;

  wire logic [7:0] byte_in  = {sh_q[6:0], si};
  wire logic       last_bit = (bit_q == 3'h7);
  wire logic       busy_l   = st_l2_q.busy;
  wire logic [15:0] rd_a    = (ph_q == PH_AL) ? {addr_q[15:8], byte_in} : addr_q;

  // status as seen by software; reserved bits are tied low
  assign stat = '{lock: lock_q, rsvd: STAT_RSVD, bg: bg_q, write_enable_latch: wel_q, busy: busy_q};

  // status crosses into the link domain through two flops on sck
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      st_l1_q <= '0;
      st_l2_q <= '0;
    end else begin
      st_l1_q <= stat;
      st_l2_q <= st_l1_q;
    end
  end

  // bit and byte counting, opcode decode; frame state dies with select
  // the pause pin is read at each rising edge, so a pause set while sck is low acts at once
  always_ff @(posedge sck or negedge lrst_n) begin
    if (!lrst_n) begin
      bit_q <= 3'h0;
      ph_q  <= PH_OP;
      op_q  <= SPE_OP_NONE;
      sh_q  <= 8'h00;
    end else if (hold_n && op_q != SPE_OP_IGNORE) begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= byte_in;
      if (last_bit && ph_q != PH_DATA) ph_q <= ph_q + 2'h1;
      if (last_bit && ph_q == PH_OP) begin
        case (byte_in)
          OP_READ:      op_q <= busy_l ? SPE_OP_IGNORE : SPE_OP_READ;
          OP_WRITE:     op_q <= SPE_OP_WRITE;
          OP_STAT_WR:   op_q <= SPE_OP_STAT_WR;
          OP_STAT_RD:   op_q <= SPE_OP_STAT_RD;
          OP_LATCH_SET: op_q <= SPE_OP_LATCH;
          OP_LATCH_CLR: op_q <= SPE_OP_LATCH;
          default:      op_q <= SPE_OP_IGNORE;
        endcase
      end
    end
  end

  // address counter, transmit byte and commit kind; these outlive the frame
  // so the system side can act on them after select rises
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      addr_q     <= 16'h0000;
      tx_q       <= 8'h00;
      stat_new_q <= 8'h00;
      kind_q     <= SPE_K_NONE;
      pg_vld_q   <= '0;
    end else if (hold_n && op_q != SPE_OP_IGNORE) begin
      kind_q <= SPE_K_NONE;
      if (last_bit) begin
        case (ph_q)
          PH_OP: begin
            // busy has crossed by the eighth clock; the first clocks of a frame
            // may still see a stale status, so the page mask is not touched there
            if (byte_in == OP_WRITE && !busy_l) pg_vld_q <= '0;
            if (byte_in == OP_LATCH_SET) kind_q <= SPE_K_SET;
            if (byte_in == OP_LATCH_CLR) kind_q <= SPE_K_CLR;
            if (byte_in == OP_STAT_RD) tx_q <= st_l2_q;
          end
          PH_AH: begin
            addr_q[15:8] <= byte_in;
            if (op_q == SPE_OP_STAT_WR) begin
              stat_new_q <= byte_in;
              kind_q     <= SPE_K_STAT;
            end
          end
          PH_AL: addr_q[7:0] <= byte_in;
          default: begin
            if (op_q == SPE_OP_WRITE && !busy_l) begin
              pg_vld_q[addr_q[PAGE_W-1:0]] <= 1'b1;
              addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 7'h01;
              kind_q <= SPE_K_MEM;
            end
          end
        endcase
        if (op_q == SPE_OP_STAT_RD) tx_q <= st_l2_q;
        if (op_q == SPE_OP_READ && (ph_q == PH_AL || ph_q == PH_DATA)) begin
          tx_q   <= mem_q[rd_a];
          addr_q <= rd_a + 16'h0001;
        end
      end
    end
  end

  // page buffer has no reset; the valid mask says which bytes are real
  always_ff @(posedge sck) begin
    if (hold_n && op_q == SPE_OP_WRITE && ph_q == PH_DATA && last_bit && !busy_l)
      pg_buf_q[addr_q[PAGE_W-1:0]] <= byte_in;
  end

  // output side on falling edges; the enable follows the pause pin only at a
  // falling edge, so it stays registered at the cost of floating half a clock late
  always_ff @(negedge sck or negedge lrst_n) begin
    if (!lrst_n) begin
      so     <= 1'b0;
      so_oe  <= 1'b0;
    end else begin
      so     <= tx_q[3'h7 - bit_q];
      so_oe  <= hold_n && ((op_q == SPE_OP_READ && ph_q == PH_DATA) ||
                           op_q == SPE_OP_STAT_RD);
    end
  end

  // select, commit kind and protect pin into the clk domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs1_q <= 1'b1;
      cs2_q <= 1'b1;
      cs3_q <= 1'b1;
      k1_q  <= 3'h0;
      k2_q  <= 3'h0;
      wp1_q <= 1'b1;
      wp2_q <= 1'b1;
      h1_q  <= 1'b1;
      h2_q  <= 1'b1;
    end else begin
      cs1_q <= cs_n;
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
      k1_q  <= kind_q;
      k2_q  <= k1_q;
      wp1_q <= wp_n;
      wp2_q <= wp1_q;
      h1_q  <= hold_n;
      h2_q  <= h1_q;
    end
  end

  // kind was stable since the last sck edge, well before select rose
  // a select rise seen under pause commits nothing: the frame is abandoned
  wire logic      cs_rise = cs2_q & ~cs3_q & h2_q;
  wire spe_kind_t kind_s  = spe_kind_t'(k2_q);
  wire logic      hw_lock = lock_q & ~wp2_q;
  wire logic      go_stat = cs_rise && kind_s == SPE_K_STAT && wel_q && !busy_q && !hw_lock;
  wire logic      go_mem  = cs_rise && kind_s == SPE_K_MEM && wel_q && !busy_q &&
                            !spe_guarded({addr_q[15:7], 7'h00}, bg_q);

  // nonvolatile cycle: copy the page on a memory write, then hold busy for the program time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pg_q      <= SPE_PG_IDLE;
      cnt_q     <= '0;
      idx_q     <= '0;
      base_q    <= '0;
      is_stat_q <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (pg_q)
        SPE_PG_IDLE: begin
          cnt_q <= '0;
          idx_q <= '0;
          if (go_stat) begin
            pg_q      <= SPE_PG_WAIT;
            is_stat_q <= 1'b1;
            busy_q    <= 1'b1;
          end else if (go_mem) begin
            pg_q      <= SPE_PG_COPY;
            base_q    <= addr_q[15:7]; // later frames reuse the address counter
            is_stat_q <= 1'b0;
            busy_q    <= 1'b1;
          end
        end
        SPE_PG_COPY: begin
          idx_q <= idx_q + 7'h01;
          if (idx_q == 7'h7F) pg_q <= SPE_PG_WAIT;
        end
        SPE_PG_WAIT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(PROG_CYCLES - 1)) begin
            pg_q   <= SPE_PG_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: pg_q <= SPE_PG_IDLE;
      endcase
    end
  end

  // array write during copy; only bytes received in this frame land
  always_ff @(posedge clk) begin
    if (pg_q == SPE_PG_COPY && pg_vld_q[idx_q])
      mem_q[{base_q, idx_q}] <= pg_buf_q[idx_q];
  end

  // lock and guard bits change only as the status cycle finishes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= LOCK_RST;
      bg_q   <= BG_RST;
    end else if (done_q && is_stat_q) begin
      lock_q <= stat_new_q[7];
      bg_q   <= stat_new_q[3:2];
    end
  end

  // latch: a set in the same cycle as a completion wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wel_q <= WEL_RST;
    end else if (cs_rise && kind_s == SPE_K_SET) begin
      wel_q <= 1'b1;
    end else if (done_q || (cs_rise && kind_s == SPE_K_CLR)) begin
      wel_q <= 1'b0;
    end
  end

  a_latch_set: assert property (@(posedge clk) disable iff (!nrst)
    cs_rise && kind_s == SPE_K_SET |=> wel_q) else $error("latch not set");
  a_latch_clr: assert property (@(posedge clk) disable iff (!nrst)
    cs_rise && kind_s == SPE_K_CLR |=> !wel_q) else $error("latch not cleared");
  a_hw_lock_blocks: assert property (@(posedge clk) disable iff (!nrst)
    pg_q == SPE_PG_IDLE && cs_rise && kind_s == SPE_K_STAT && hw_lock |=> !busy_q)
    else $error("status write ran under hardware lock");
  a_no_latch_blocks: assert property (@(posedge clk) disable iff (!nrst)
    !busy_q && cs_rise && !wel_q |=> !busy_q)
    else $error("write ran without latch");
  a_guard_blocks: assert property (@(posedge clk) disable iff (!nrst)
    !busy_q && cs_rise && kind_s == SPE_K_MEM && spe_guarded({addr_q[15:7], 7'h00}, bg_q)
    |=> !busy_q) else $error("guarded write ran");
  a_write_starts: assert property (@(posedge clk) disable iff (!nrst)
    go_mem |=> busy_q ##128 pg_q == SPE_PG_WAIT) else $error("write cycle did not start");
  a_stat_stable: assert property (@(posedge clk) disable iff (!nrst)
    busy_q && !done_q |=> $stable(lock_q) && $stable(bg_q))
    else $error("status bits changed mid cycle");
  a_done_clears: assert property (@(posedge clk) disable iff (!nrst)
    $fell(busy_q) && !(cs_rise && kind_s == SPE_K_SET) |=> !wel_q)
    else $error("latch survived write end");
  a_busy_length: assert property (@(posedge clk) disable iff (!nrst)
    go_stat |=> busy_q[*2]) else $error("busy too short");
  a_rsvd_zero: assert property (@(posedge sck) disable iff (!nrst)
    op_q == SPE_OP_STAT_RD |-> tx_q[6:4] == STAT_RSVD) else $error("reserved bits not zero");

  c_mem_write: cover property (@(posedge clk) disable iff (!nrst) go_mem ##1 busy_q);
  c_stat_write: cover property (@(posedge clk) disable iff (!nrst) done_q && is_stat_q);
  c_latch_set: cover property (@(posedge clk) disable iff (!nrst) $rose(wel_q));

endmodule : spe_eeprom

/* File: sim/spe_host.sv */
`timescale 1ns/1ps
// behavioural spi host in mode 0; its clock only runs inside frames
module spe_host (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so,
  input  wire logic so_oe
);
  int   hold_at;  // bit before which a pause goes in; equal to the count pauses past the end
  logic held_oe;  // output enable seen while paused

  initial begin
    sck     = 1'b0;
    cs_n    = 1'b1;
    si      = 1'b0;
    hold_n  = 1'b1;
    hold_at = -1;
    held_oe = 1'b0;
  end

  // n bits of tx go out msb first; rx keeps the last 16 bits seen on so
  task automatic xfer(input logic [39:0] tx, input int n, output logic [15:0] rx,
                      output logic oe);
    rx      = 16'h0000;
    oe      = 1'b0;
    held_oe = 1'b0;
    cs_n    = 1'b0;
    for (int i = 0; i < n; i++) begin
      // pause entered with sck low, left with sck high; the clocks between
      // carry junk on si and must shift nothing
      if (i == hold_at) begin
        #2 hold_n = 1'b0;
        for (int j = 0; j < 3; j++) begin
          si = ~si;
          #4 sck = 1'b1;
          if (j == 2) #2 hold_n = 1'b1;
          #4 sck = 1'b0;
          #2;
          if (j < 2) held_oe = held_oe | so_oe;
        end
      end
      si = tx[39-i];
      #6 sck = 1'b1;
      rx = {rx[14:0], so};
      oe = oe | so_oe;
      #6 sck = 1'b0;
    end
    // a pause past the last bit stays on while select rises
    if (hold_at == n) #2 hold_n = 1'b0;
    // select rises before any further rising clock, so the count is exact
    #6 cs_n = 1'b1;
    si = ~si; // a released line must not keep showing the last bit
    #200 hold_n = 1'b1;
    hold_at = -1;
    #200;
  endtask : xfer
endmodule : spe_host

/* File: sim/spe_eeprom_tb.sv */
`timescale 1ns/1ps
module spe_eeprom_tb;
  import spe_pkg::*;
  localparam int PROG = 20;
  logic        clk;
  logic        nrst;
  logic        wp_n;
  logic        hold_n;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe;
  logic [15:0] rx;
  logic        oe;
  int          errors;
  int          n_tests;

  spe_eeprom #(.PROG_CYCLES(PROG)) i_spe_eeprom (.clk(clk), .nrst(nrst), .sck(sck),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .hold_n(hold_n), .so(so), .so_oe(so_oe));
  spe_host i_spe_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so(so), .so_oe(so_oe));

  // system clock, unrelated in phase to the host's link clock
  always #25 clk = ~clk;

  task automatic stop_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op, input int n);
    i_spe_host.xfer({op, 32'h0}, n, rx, oe);
  endtask : cmd

  task automatic stat(input logic [7:0] exp);
    cmd(OP_STAT_RD, 16);
    chk(rx[7:0], exp);
  endtask : stat

  // polls busy under a bound; a hang ends the run
  task automatic wait_idle;
    int k;
    for (k = 0; k < 60; k++) begin
      cmd(OP_STAT_RD, 16);
      if (rx[0] === 1'b0) break;
    end
    if (k == 60) begin
      errors++;
      $display("Error at %0t: busy never cleared", $time);
      stop_test();
    end
  endtask : wait_idle

  task automatic mem_wr(input logic [15:0] a, input logic [15:0] d, input int n);
    cmd(OP_LATCH_SET, 8);
    i_spe_host.xfer({OP_WRITE, a, d}, n, rx, oe);
    wait_idle();
  endtask : mem_wr

  task automatic stat_wr(input logic [7:0] d, input int n);
    i_spe_host.xfer({OP_STAT_WR, d, 24'h0}, n, rx, oe);
  endtask : stat_wr

  task automatic rd(input logic [15:0] a, input int n);
    i_spe_host.xfer({OP_READ, a, 16'h0}, n, rx, oe);
  endtask : rd

  task automatic set_wp(input logic v);
    @(posedge clk);
    #1 wp_n = v;
    repeat (10) @(posedge clk);
  endtask : set_wp

  // watchdog so no hang outlives the closing report
  initial begin
    #2ms;
    errors++;
    $display("Error at %0t: run timed out", $time);
    stop_test();
  end

  initial begin
    clk     = 1'b0;
    nrst    = 1'b0;
    wp_n    = 1'b1;
    errors  = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    stat(8'h00);
    stat_wr(8'h8C, 16);
    stat(8'h00);
    cmd(OP_LATCH_SET, 8);
    stat(8'h02);
    cmd(OP_LATCH_CLR, 8);
    stat(8'h00);
    // fill slots while nothing is guarded; page writes wrap inside the page
    mem_wr(16'hC000, 16'h5A00, 32);
    stat(8'h00);
    mem_wr(16'h107F, 16'h0102, 40);
    mem_wr(16'hFFFF, 16'hAABB, 40);
    mem_wr(16'h0000, 16'h3C00, 32);
    rd(16'h107F, 32);
    chk(rx[7:0], 8'h01);
    rd(16'h1000, 32);
    chk(rx[7:0], 8'h02);
    rd(16'hFF80, 32);
    chk(rx[7:0], 8'hBB);
    rd(16'hFFFF, 40);
    chk(rx[15:8], 8'hAA);
    chk(rx[7:0], 8'h3C);
    // one clock too many cancels the write
    mem_wr(16'h0000, 16'h9900, 33);
    rd(16'h0000, 32);
    chk(rx[7:0], 8'h3C);
    cmd(OP_LATCH_CLR, 8);
    i_spe_host.xfer({OP_WRITE, 16'h0000, 16'h7700}, 32, rx, oe);
    rd(16'h0000, 32);
    chk(rx[7:0], 8'h3C);
    // a read sent while the cycle runs gets no answer
    mem_wr(16'h0000, 16'h5500, 32);
    cmd(OP_LATCH_SET, 8);
    i_spe_host.xfer({OP_WRITE, 16'h0000, 16'h6600}, 32, rx, oe);
    rd(16'h0000, 32);
    chk({7'h00, oe}, 8'h00);
    wait_idle();
    rd(16'h0000, 32);
    chk(rx[7:0], 8'h66);
    cmd(OP_LATCH_SET, 8);
    stat_wr(8'hFC, 17);
    stat(8'h02);
    stat_wr(8'hFC, 16);
    stat(8'h03);
    wait_idle();
    stat(8'h8C);
    mem_wr(16'h0000, 16'h1100, 32);
    rd(16'h0000, 32);
    chk(rx[7:0], 8'h66);
    // hardware lock: the protect pin goes low after the lock bit
    set_wp(1'b0);
    cmd(OP_LATCH_SET, 8);
    stat_wr(8'h04, 16);
    wait_idle();
    stat(8'h8E);
    set_wp(1'b1);
    stat_wr(8'h04, 16);
    wait_idle();
    stat(8'h04);
    mem_wr(16'hC000, 16'h1100, 32);
    rd(16'hC000, 32);
    chk(rx[7:0], 8'h5A);
    mem_wr(16'hBFFF, 16'h7E00, 32);
    rd(16'hBFFF, 32);
    chk(rx[7:0], 8'h7E);
    // an unknown opcode leaves the output undriven for the rest of the frame
    i_spe_host.xfer({8'hFF, OP_READ, 16'h0000, 8'h00}, 40, rx, oe);
    chk({7'h00, oe}, 8'h00);
    // pause inside the data byte: held clocks shift nothing and the output floats
    i_spe_host.hold_at = 28;
    rd(16'h107F, 32);
    chk(rx[7:0], 8'h01);
    chk({7'h00, i_spe_host.held_oe}, 8'h00);
    // select rising under a pause abandons a complete write frame
    cmd(OP_LATCH_SET, 8);
    i_spe_host.hold_at = 32;
    i_spe_host.xfer({OP_WRITE, 16'h0000, 16'h4400}, 32, rx, oe);
    stat(8'h06);
    rd(16'h0000, 32);
    chk(rx[7:0], 8'h66);
    stop_test();
  end
endmodule : spe_eeprom_tb
